/* epi_device_model.sv */
module epi_device_model
(
   input wire logic chip_en_n_i,
   input wire logic out_strobe_n_i,
   input wire logic write_pulse_n_i,
   input wire logic [12:0] addr_i,
   input wire logic [7:0] bus_i,
   input wire logic vpp_i,
   input wire logic test_i,
   output logic [7:0] q_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:8191];
   logic lock_cell;
   logic [7:0] last;
   logic reading, lock_read, driving;
   logic [7:0] drv_val;
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'hff;
      lock_cell = 1'b1;
      last = 8'h00;
   end
   assign reading = !chip_en_n_i && !out_strobe_n_i && write_pulse_n_i;
   assign lock_read = reading && test_i && !addr_i[6];
   assign driving = lock_read || (reading && lock_cell);
   assign drv_val = lock_read ? {lock_cell, mem[addr_i][6:0]} : mem[addr_i];
   assign q_o = driving ? drv_val : ~last;
   always @(drv_val or driving)
   begin
      if (driving)
         last = drv_val;
   end
   always @(negedge write_pulse_n_i)
   begin
      if (!chip_en_n_i && vpp_i && !test_i)
         mem[addr_i] = mem[addr_i] & bus_i;
   end
   always @(negedge bus_i[7])
   begin
      if (chip_en_n_i && out_strobe_n_i && write_pulse_n_i && addr_i[4] && vpp_i && test_i)
         lock_cell = 1'b0;
   end
endmodule // epi_device_model

/* epi_map.svh */
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
`define EPI_CLK_HZ 25000000
`define EPI_PRIME_US 1000
`define EPI_PRIME_CYC ((`EPI_PRIME_US * (`EPI_CLK_HZ / 1000000)))
`define EPI_FINAL_MULT 4
`define EPI_MAX_PRIME 4'hf
`define EPI_SETTLE_CYC 16'h0004
`define EPI_STROBE_CYC 16'h0008
`define EPI_LOCK_ADDR_BIT 4
`define EPI_VERIFY_ADDR_BIT 6
`define EPI_LOCK_DATA_BIT 7
`define EPI_ADDR_W 13
`define EPI_ERASED_BYTE 8'hff
`endif

/* epi_pkg.sv */
package epi_pkg;
`include "epi_map.svh"
   typedef enum logic [2:0]
   {
      EPI_CMD_PROGRAM,
      EPI_CMD_READ,
      EPI_CMD_PROTECT,
      EPI_CMD_PROTECT_VERIFY,
      EPI_CMD_DISABLE
   } epi_cmd_t;
   typedef enum logic [1:0]
   {
      EPI_RES_OK,
      EPI_RES_FAIL,
      EPI_RES_PROTECTED
   } epi_res_t;
endpackage

/* epi_programmer.sv */
`include "epi_map.svh"
module epi_programmer
   import epi_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire epi_cmd_t cmd_i,
   input wire logic [12:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic res_valid_o,
   output epi_res_t res_o,
   output logic [7:0] res_data_o,
   output logic [3:0] res_pulses_o,
   output logic chip_en_n_o,
   output logic out_strobe_n_o,
   output logic write_pulse_n_o,
   output logic [12:0] addr_o,
   output logic [7:0] byte_lines_o,
   output logic byte_lines_oe_o,
   input wire logic [7:0] byte_lines_i,
   output logic vpp_high_o,
   output logic vcc_high_o,
   output logic test_mode_input_o
);
   typedef enum logic [3:0]
   {
      ST_IDLE, ST_SETUP, ST_PULSE, ST_VSETUP, ST_VSTROBE, ST_FINAL, ST_RSTROBE,
      ST_PSETUP, ST_PPULSE, ST_FSETUP, ST_DONE
   } epi_state_t;
   epi_state_t state;
   epi_cmd_t cmd;
   logic [7:0] data;
   logic [3:0] prime_cnt;
   logic [7:0] s1, s2, s3;
   logic [7:0] rx;
   epi_timer_if tif ();
   epi_timer u_timer (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .tif(tif));
   // Three-stage pin sampling; a change counts once stages two and three agree
   always_ff @(posedge core_clk_i)
   begin
      s1 <= byte_lines_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
         rx <= s3;
      end
   end
   wire verify_ok = (rx == data);
   wire retry_ok = (prime_cnt != `EPI_MAX_PRIME);
   wire [31:0] prime_cyc = 32'(`EPI_PRIME_CYC);
   wire [31:0] final_cyc = 32'(`EPI_PRIME_CYC * `EPI_FINAL_MULT) * {28'h0000000, prime_cnt};
   wire [31:0] settle_cyc = {16'h0000, `EPI_SETTLE_CYC};
   wire [31:0] strobe_cyc = {16'h0000, `EPI_STROBE_CYC};
   wire lock_bit = rx[`EPI_LOCK_DATA_BIT];
   wire setup_end = (state == ST_SETUP || state == ST_VSETUP || state == ST_PSETUP
      || state == ST_FSETUP) && tif.done;
   wire next_pulse = state == ST_VSTROBE && tif.done && cmd == EPI_CMD_PROGRAM
      && (verify_ok || retry_ok);
   assign tif.start = cmd_valid_i && cmd_ready_o
      || setup_end
      || state == ST_PULSE && tif.done
      || next_pulse;
   assign tif.count = (state == ST_SETUP || state == ST_PSETUP) ? prime_cyc
      : (state == ST_FSETUP) ? final_cyc
      : (state == ST_VSETUP) ? strobe_cyc
      : settle_cyc;
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         state <= ST_IDLE;
         cmd <= EPI_CMD_DISABLE;
         data <= `EPI_ERASED_BYTE;
         prime_cnt <= 4'h0;
         cmd_ready_o <= 1'b0;
         res_valid_o <= 1'b0;
         res_o <= EPI_RES_OK;
         res_data_o <= 8'h00;
         res_pulses_o <= 4'h0;
         chip_en_n_o <= 1'b1;
         out_strobe_n_o <= 1'b1;
         write_pulse_n_o <= 1'b1;
         addr_o <= 13'h0000;
         byte_lines_o <= 8'h00;
         byte_lines_oe_o <= 1'b0;
         vpp_high_o <= 1'b0;
         vcc_high_o <= 1'b0;
         test_mode_input_o <= 1'b0;
      end
      else
      begin
         res_valid_o <= 1'b0;
         unique case (state)
            ST_IDLE:
            begin
               cmd_ready_o <= 1'b1;
               out_strobe_n_o <= 1'b1;
               write_pulse_n_o <= 1'b1;
               byte_lines_oe_o <= 1'b0;
               if (cmd_valid_i && cmd_ready_o)
               begin
                  cmd_ready_o <= 1'b0;
                  cmd <= cmd_i;
                  data <= cmd_data_i;
                  addr_o <= cmd_addr_i;
                  prime_cnt <= 4'h0;
                  unique case (cmd_i)
                     EPI_CMD_PROGRAM:
                     begin
                        vpp_high_o <= 1'b1;
                        vcc_high_o <= 1'b1;
                        chip_en_n_o <= 1'b0;
                        byte_lines_o <= cmd_data_i;
                        byte_lines_oe_o <= 1'b1;
                        state <= ST_SETUP;
                     end
                     EPI_CMD_READ, EPI_CMD_PROTECT_VERIFY:
                     begin
                        vpp_high_o <= 1'b0;
                        vcc_high_o <= 1'b0;
                        chip_en_n_o <= 1'b0;
                        test_mode_input_o <= (cmd_i == EPI_CMD_PROTECT_VERIFY);
                        addr_o[`EPI_VERIFY_ADDR_BIT] <= (cmd_i == EPI_CMD_PROTECT_VERIFY)
                           ? 1'b0 : cmd_addr_i[`EPI_VERIFY_ADDR_BIT];
                        state <= ST_VSETUP;
                     end
                     EPI_CMD_PROTECT:
                     begin
                        chip_en_n_o <= 1'b1;
                        vpp_high_o <= 1'b1;
                        vcc_high_o <= 1'b1;
                        test_mode_input_o <= 1'b1;
                        addr_o[`EPI_LOCK_ADDR_BIT] <= 1'b1;
                        byte_lines_o <= `EPI_ERASED_BYTE;
                        byte_lines_oe_o <= 1'b1;
                        state <= ST_PSETUP;
                     end
                     default:
                     begin
                        chip_en_n_o <= 1'b0;
                        vpp_high_o <= 1'b0;
                        vcc_high_o <= 1'b0;
                        test_mode_input_o <= 1'b0;
                        res_o <= EPI_RES_OK;
                        state <= ST_DONE;
                     end
                  endcase
               end
            end
            ST_SETUP:
            begin
               if (tif.done)
               begin
                  write_pulse_n_o <= 1'b0;
                  prime_cnt <= prime_cnt + 4'h1;
                  state <= ST_PULSE;
               end
            end
            ST_PULSE:
            begin
               if (tif.done)
               begin
                  write_pulse_n_o <= 1'b1;
                  byte_lines_oe_o <= 1'b0;
                  state <= ST_VSETUP;
               end
            end
            ST_VSETUP:
            begin
               if (tif.done)
               begin
                  out_strobe_n_o <= 1'b0;
                  state <= ST_VSTROBE;
               end
            end
            ST_VSTROBE:
            begin
               if (tif.done)
               begin
                  out_strobe_n_o <= 1'b1;
                  res_data_o <= rx;
                  if (cmd == EPI_CMD_PROGRAM && verify_ok)
                  begin
                     byte_lines_o <= data;
                     byte_lines_oe_o <= 1'b1;
                     state <= ST_FSETUP;
                  end
                  else if (cmd == EPI_CMD_PROGRAM && retry_ok)
                  begin
                     byte_lines_oe_o <= 1'b1;
                     state <= ST_SETUP;
                  end
                  else
                  begin
                     res_o <= (cmd == EPI_CMD_PROGRAM) ? EPI_RES_FAIL
                        : (cmd == EPI_CMD_PROTECT_VERIFY && !lock_bit) ? EPI_RES_PROTECTED
                        : EPI_RES_OK;
                     state <= ST_DONE;
                  end
               end
            end
            ST_FSETUP:
            begin
               if (tif.done)
               begin
                  write_pulse_n_o <= 1'b0;
                  state <= ST_FINAL;
               end
            end
            ST_FINAL:
            begin
               if (tif.done)
               begin
                  write_pulse_n_o <= 1'b1;
                  byte_lines_oe_o <= 1'b0;
                  res_o <= EPI_RES_OK;
                  state <= ST_DONE;
               end
            end
            ST_PSETUP:
            begin
               if (tif.done)
               begin
                  byte_lines_o[`EPI_LOCK_DATA_BIT] <= 1'b0;
                  state <= ST_PPULSE;
               end
            end
            ST_PPULSE:
            begin
               if (tif.done)
               begin
                  byte_lines_o[`EPI_LOCK_DATA_BIT] <= 1'b1;
                  byte_lines_oe_o <= 1'b0;
                  res_o <= EPI_RES_OK;
                  state <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               res_valid_o <= 1'b1;
               res_pulses_o <= prime_cnt;
               vpp_high_o <= 1'b0;
               vcc_high_o <= 1'b0;
               test_mode_input_o <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // epi_programmer

/* epi_programmer_properties.sv */
module epi_programmer_chk
   import epi_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic chip_en_n_o,
   input wire logic out_strobe_n_o,
   input wire logic write_pulse_n_o,
   input wire logic [12:0] addr_o,
   input wire logic [7:0] byte_lines_o,
   input wire logic byte_lines_oe_o,
   input wire logic vpp_high_o,
   input wire logic vcc_high_o,
   input wire logic test_mode_input_o
);
   localparam int PRIME = 25000;
   int low_cnt;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i || write_pulse_n_o)
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;
   end
   chk_prog_levels: assert property (
      !write_pulse_n_o |-> out_strobe_n_o && vpp_high_o && vcc_high_o)
      else $error("program pulse without program levels");
   chk_no_unsel_write: assert property (chip_en_n_o |-> write_pulse_n_o)
      else $error("program pulse while chip enable high");
   chk_data_settled: assert property (
      $fell(write_pulse_n_o) |-> byte_lines_oe_o && $past(byte_lines_oe_o)
      && $stable(byte_lines_o) && $stable(addr_o))
      else $error("address or data moved at program pulse start");
   chk_pulse_width: assert property (
      $rose(write_pulse_n_o) |-> low_cnt > 0 && low_cnt % PRIME == 0)
      else $error("program pulse length not a whole prime multiple");
   chk_prime_verify: assert property (
      $rose(write_pulse_n_o) && low_cnt == PRIME |-> ##[1:30] !out_strobe_n_o)
      else $error("no verify strobe after prime pulse");
   chk_read_no_drive: assert property (
      !out_strobe_n_o |-> !byte_lines_oe_o && !chip_en_n_o && write_pulse_n_o)
      else $error("strobe low with wrong levels or bus driven");
   chk_lock_levels: assert property (
      test_mode_input_o && byte_lines_oe_o && !byte_lines_o[7] |-> chip_en_n_o
      && out_strobe_n_o && write_pulse_n_o && addr_o[4] && vpp_high_o)
      else $error("lock pulse with wrong levels");
   chk_lock_verify: assert property (
      test_mode_input_o && !out_strobe_n_o |-> !addr_o[6] && !vpp_high_o)
      else $error("lock verify with wrong levels");
endmodule // epi_programmer_chk

bind epi_programmer epi_programmer_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
   .chip_en_n_o(chip_en_n_o), .out_strobe_n_o(out_strobe_n_o),
   .write_pulse_n_o(write_pulse_n_o), .addr_o(addr_o), .byte_lines_o(byte_lines_o),
   .byte_lines_oe_o(byte_lines_oe_o), .vpp_high_o(vpp_high_o), .vcc_high_o(vcc_high_o),
   .test_mode_input_o(test_mode_input_o));

/* epi_tb.sv */
module tb
   import epi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   epi_cmd_t cmd_i = EPI_CMD_DISABLE;
   logic [12:0] cmd_addr_i = 13'h0000;
   logic [7:0] cmd_data_i = 8'h00;
   logic cmd_ready_o, res_valid_o, chip_en_n_o, out_strobe_n_o, write_pulse_n_o;
   logic byte_lines_oe_o, vpp_high_o, vcc_high_o, test_mode_input_o;
   epi_res_t res_o;
   logic [7:0] res_data_o, byte_lines_o, byte_lines_i, dev_q;
   logic [3:0] res_pulses_o;
   logic [12:0] addr_o;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #20 core_clk_i = ~core_clk_i;
   assign byte_lines_i = byte_lines_oe_o ? byte_lines_o : dev_q;
   epi_programmer dut (.core_clk_i, .nrst_i, .cmd_valid_i, .cmd_i, .cmd_addr_i, .cmd_data_i,
      .cmd_ready_o, .res_valid_o, .res_o, .res_data_o, .res_pulses_o, .chip_en_n_o,
      .out_strobe_n_o, .write_pulse_n_o, .addr_o, .byte_lines_o, .byte_lines_oe_o,
      .byte_lines_i, .vpp_high_o, .vcc_high_o, .test_mode_input_o);
   epi_device_model u_dev (.chip_en_n_i(chip_en_n_o), .out_strobe_n_i(out_strobe_n_o),
      .write_pulse_n_i(write_pulse_n_o), .addr_i(addr_o), .bus_i(byte_lines_i),
      .vpp_i(vpp_high_o), .test_i(test_mode_input_o), .q_o(dev_q));
   task automatic finish_test();
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h got %h", what, exp, got);
      end
   endtask
   task automatic check_res(input epi_res_t exp);
      check("result", {6'h00, exp}, {6'h00, res_o});
   endtask
   task automatic run_cmd(input epi_cmd_t c, input logic [12:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      cmd_i = c;
      cmd_addr_i = a;
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      while (cmd_ready_o !== 1'b1)
         @(negedge core_clk_i);
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      while (res_valid_o !== 1'b1)
         @(negedge core_clk_i);
   endtask
   task automatic t_idle_pins();
      check("idle pins", 8'h70, {1'b0, chip_en_n_o, out_strobe_n_o, write_pulse_n_o,
         byte_lines_oe_o, vpp_high_o, vcc_high_o, test_mode_input_o});
   endtask
   task automatic t_disable();
      run_cmd(EPI_CMD_DISABLE, 13'h0000, 8'h00);
      check_res(EPI_RES_OK);
      check("disable pins", 8'h06, {5'h00, out_strobe_n_o, write_pulse_n_o, byte_lines_oe_o});
   endtask
   task automatic t_read(input logic [12:0] a, input logic [7:0] exp);
      run_cmd(EPI_CMD_READ, a, 8'h00);
      check_res(EPI_RES_OK);
      check("read data", exp, res_data_o);
   endtask
   task automatic t_program();
      run_cmd(EPI_CMD_PROGRAM, 13'h00a5, 8'h3c);
      check_res(EPI_RES_OK);
      check("prime pulses", 8'h01, {4'h0, res_pulses_o});
      t_read(13'h00a5, 8'h3c);
      t_read(13'h00a4, 8'hff);
   endtask
   task automatic t_protect();
      run_cmd(EPI_CMD_PROTECT_VERIFY, 13'h0000, 8'h00);
      check_res(EPI_RES_OK);
      check("lock bit", 8'h01, {7'h00, res_data_o[7]});
      run_cmd(EPI_CMD_PROTECT, 13'h0000, 8'h00);
      check_res(EPI_RES_OK);
      run_cmd(EPI_CMD_PROTECT_VERIFY, 13'h0000, 8'h00);
      check_res(EPI_RES_PROTECTED);
      check("lock bit", 8'h00, {7'h00, res_data_o[7]});
   endtask
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 250000)
      begin
         n_errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (5) @(negedge core_clk_i);
      nrst_i = 1'b1;
      @(negedge core_clk_i);
      t_idle_pins();
      t_disable();
      t_read(13'h1fff, 8'hff);
      t_program();
      t_protect();
      finish_test();
   end
endmodule // tb

/* epi_timer.sv */
module epi_timer
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   epi_timer_if.timer tif
);
   logic [31:0] remain;
   logic running;
   wire last = running && (remain == 32'h00000001);
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         remain <= 32'h00000000;
         running <= 1'b0;
      end
      else
      begin
         if (tif.start)
         begin
            remain <= tif.count;
            running <= 1'b1;
         end
         else if (running)
         begin
            remain <= remain - 32'h00000001;
            running <= !last;
         end
      end
   end
   // Done in the last counted cycle, so the owner acts after exactly count cycles
   assign tif.done = last;
endmodule // epi_timer

/* epi_timer_if.sv */
interface epi_timer_if;
   logic start;
   logic [31:0] count;
   logic done;
   modport owner (output start, output count, input done);
   modport timer (input start, input count, output done);
endinterface
